// File: pkg/dbc_map.svh
// Purpose: Offsets, field positions, reset values and codes of the debugger control block
// Assumes: One 32-bit aligned word per register on AHB-Lite
// Notes: Definitions only
`ifndef DBC_MAP_SVH
`define DBC_MAP_SVH
// ==========================================
// Register map
`define DBC_OFF_CTRL 12'h000
`define DBC_CTRL_RESET 8'h00
// ==========================================
// Control register fields
`define DBC_BIT_HALT 7
`define DBC_BIT_ARM 6
`define DBC_BIT_ACK 5
`define DBC_BIT_RST 0
// ==========================================
// Codes
`define DBC_BRK_OPCODE 8'h00
`define DBC_CMD_EXEC 8'h12
`define DBC_OPLEN_MIN 3'h1
`define DBC_OPLEN_MAX 3'h5
`endif

// File: pkg/dbc_pkg.sv
// Purpose: Types of the debugger control block
// Assumes: Constants live in dbc_map.svh
// Notes: State of each module is one packed struct
package dbc_pkg;
  // ==========================================
  // Top state
  typedef struct packed {
    logic halt;
    logic arm;
    logic ack;
    logic core_reset;
    logic fetch_en;
    logic brk_nop;
    logic wr_pend;
    logic hreadyout;
    logic [31:0] hrdata;
  } dbc_state_type;
  // ==========================================
  // Command filter state
  typedef enum logic [1:0] {
    DBC_F_IDLE = 2'b00,
    DBC_F_OPCODE = 2'b01,
    DBC_F_DISCARD = 2'b10
  } dbc_fstate_type;
  typedef struct packed {
    dbc_fstate_type st;
    logic [2:0] left;
    logic first;
    logic exec_valid;
    logic [7:0] exec_byte;
    logic discard;
  } dbc_filt_type;
endpackage : dbc_pkg

// File: logic/dbc_cmd_filter.sv
// Purpose: Gate of the execute-opcode debug command
// Assumes: Byte strobes come from the link decoder on the same clock
// Notes: Opcode length arrives with the first opcode byte
`timescale 1ns/1ns
`include "dbc_map.svh"
module dbc_cmd_filter (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic [2:0] op_len,
  input wire logic allowed,
  output logic exec_valid_r,
  output logic [7:0] exec_byte_r,
  output logic discard_r
);
  dbc_pkg::dbc_filt_type fs_r;
  dbc_pkg::dbc_filt_type fs_nxt;

  // ==========================================
  // Next state
  always_comb begin
    fs_nxt = fs_r;
    fs_nxt.exec_valid = 1'b0;
    fs_nxt.discard = 1'b0;
    case (fs_r.st)
      dbc_pkg::DBC_F_IDLE: begin
        if (byte_valid && byte_data == `DBC_CMD_EXEC) begin
          // Permission frozen at the command byte
          fs_nxt.st = allowed ? dbc_pkg::DBC_F_OPCODE : dbc_pkg::DBC_F_DISCARD; // (R7)
          fs_nxt.first = 1'b1;
        end
      end
      dbc_pkg::DBC_F_OPCODE: begin
        if (byte_valid) begin
          fs_nxt.exec_valid = 1'b1;
          fs_nxt.exec_byte = byte_data;
          fs_nxt.first = 1'b0;
          if (fs_r.first) begin
            // Out-of-range lengths clamp so the stream never locks up
            if (op_len < `DBC_OPLEN_MIN) begin
              fs_nxt.left = 3'h0;
            end else if (op_len > `DBC_OPLEN_MAX) begin
              fs_nxt.left = `DBC_OPLEN_MAX - 3'h1;
            end else begin
              fs_nxt.left = op_len - 3'h1;
            end
          end else begin
            fs_nxt.left = fs_r.left - 3'h1;
          end
          if (fs_nxt.left == 3'h0) begin
            fs_nxt.st = dbc_pkg::DBC_F_IDLE;
          end
        end
      end
      dbc_pkg::DBC_F_DISCARD: begin
        if (byte_valid) begin
          fs_nxt.discard = 1'b1; // (R7)
          fs_nxt.st = dbc_pkg::DBC_F_IDLE;
        end
      end
      default: begin
        fs_nxt.st = dbc_pkg::DBC_F_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fs_r <= '0;
    end else begin
      fs_r <= fs_nxt;
    end
  end

  assign exec_valid_r = fs_r.exec_valid;
  assign exec_byte_r = fs_r.exec_byte;
  assign discard_r = fs_r.discard;

  // ==========================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_cmd_denied;
    byte_valid && byte_data == `DBC_CMD_EXEC && fs_r.st == dbc_pkg::DBC_F_IDLE && !allowed;
  endsequence
  property p_denied_discard;
    s_cmd_denied ##1 byte_valid |=> discard_r && !exec_valid_r;
  endproperty
  a_denied_discard: assert property (p_denied_discard) else $error("denied command byte not discarded"); // (R7)

  property p_allowed_exec;
    byte_valid && byte_data == `DBC_CMD_EXEC && fs_r.st == dbc_pkg::DBC_F_IDLE && allowed
      ##1 byte_valid |=> exec_valid_r && !discard_r && exec_byte_r == $past(byte_data);
  endproperty
  a_allowed_exec: assert property (p_allowed_exec) else $error("allowed opcode byte not passed"); // (R7)
endmodule : dbc_cmd_filter

// File: logic/dbc_top.sv
// Purpose: Debugger control register with halt, breakpoint arm and reset request
// Assumes: Zero-wait AHB-Lite slave; read protection and opcode decode on hclk
// Notes: Only the low byte of the word holds the register
`timescale 1ns/1ns
`include "dbc_map.svh"
// Behaviour
// (R1) Halt flag at 1 stops core instruction fetch; at 0 core runs.
// (R2) Clearing the halt flag lets the core fetch and execute again.
// (R3) Armed breakpoint opcode decoded by core sets the halt flag.
// (R4) Unarmed breakpoint opcode 00H acts as no-operation, halt flag unchanged.
// (R5) Under read protection writing 0 to halt is ignored; only reset clears.
// (R6) Writes give reset-and-stop, reset-and-go, and run that releases a halted core.
// (R7) Command 12H opcode runs only halted and unprotected; else one byte discarded.
// (R8) Register resets to zero; bits 4 to 1 read-only, reading zero.
module dbc_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic read_protect,
  input wire logic opcode_valid,
  input wire logic [7:0] opcode,
  input wire logic link_byte_valid,
  input wire logic [7:0] link_byte,
  input wire logic [2:0] link_op_len,
  output logic core_halt,
  output logic core_fetch_en,
  output logic core_reset_req,
  output logic brk_nop,
  output logic ack_enable,
  output logic exec_valid,
  output logic [7:0] exec_byte,
  output logic exec_discard
);
  dbc_pkg::dbc_state_type st_r;
  dbc_pkg::dbc_state_type st_nxt;
  logic addr_take;
  logic wr_now;
  logic brk_hit;
  logic [7:0] wd;

  // ==========================================
  // Register read image
  function automatic logic [31:0] ctrl_image(input dbc_pkg::dbc_state_type s);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[`DBC_BIT_HALT] = s.halt;
    v[`DBC_BIT_ARM] = s.arm;
    v[`DBC_BIT_ACK] = s.ack;
    v[`DBC_BIT_RST] = s.core_reset;
    return v; // (R8)
  endfunction : ctrl_image

  // Word decode shared by bus logic and checks
  function automatic logic ctrl_hit(input logic [11:0] a);
    return a[11:2] == 10'(`DBC_OFF_CTRL >> 2);
  endfunction : ctrl_hit

  // ==========================================
  // Next state
  always_comb begin
    addr_take = hsel && hready && htrans[1];
    wr_now = st_r.wr_pend;
    wd = hwdata[7:0];
    brk_hit = opcode_valid && opcode == `DBC_BRK_OPCODE;
    st_nxt = st_r;
    st_nxt.hreadyout = 1'b1;
    st_nxt.core_reset = 1'b0;
    st_nxt.brk_nop = 1'b0;
    // Only one register: only the word at offset 000H decodes to it, other words are ignored
    st_nxt.wr_pend = addr_take && hwrite && ctrl_hit(haddr);
    if (wr_now) begin
      st_nxt.arm = wd[`DBC_BIT_ARM];
      st_nxt.ack = wd[`DBC_BIT_ACK];
      st_nxt.core_reset = wd[`DBC_BIT_RST]; // (R6)
      if (wd[`DBC_BIT_HALT]) begin
        st_nxt.halt = 1'b1; // (R6)
      end else if (!read_protect) begin
        st_nxt.halt = 1'b0; // (R2) (R5) (R6)
      end
    end
    // Breakpoint uses the arm bit in force before the write lands
    if (brk_hit) begin
      if (st_r.arm) begin
        st_nxt.halt = 1'b1; // (R3)
      end else begin
        st_nxt.brk_nop = 1'b1; // (R4)
      end
    end
    st_nxt.fetch_en = !st_nxt.halt; // (R1)
    // Read image taken from next value so a write just before is seen
    if (addr_take && !hwrite && ctrl_hit(haddr)) begin
      st_nxt.hrdata = ctrl_image(st_nxt);
    end else begin
      st_nxt.hrdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '{halt: 1'b0, arm: 1'b0, ack: 1'b0, core_reset: 1'b0, fetch_en: 1'b1,
                brk_nop: 1'b0, wr_pend: 1'b0, hreadyout: 1'b1, hrdata: 32'h0000_0000}; // (R8)
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================
  // Outputs
  assign hreadyout = st_r.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = st_r.hrdata;
  assign core_halt = st_r.halt; // (R1)
  assign core_fetch_en = st_r.fetch_en; // (R1)
  assign core_reset_req = st_r.core_reset;
  assign brk_nop = st_r.brk_nop;
  assign ack_enable = st_r.ack;

  // ==========================================
  // Execute command gate
  dbc_cmd_filter u_filter (
    .hclk(hclk),
    .hresetn(hresetn),
    .byte_valid(link_byte_valid),
    .byte_data(link_byte),
    .op_len(link_op_len),
    .allowed(st_r.halt && !read_protect), // (R7)
    .exec_valid_r(exec_valid),
    .exec_byte_r(exec_byte),
    .discard_r(exec_discard)
  );

  // ==========================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_fetch_follows_halt;
    core_fetch_en == !core_halt;
  endproperty
  a_fetch_follows_halt: assert property (p_fetch_follows_halt) else $error("fetch enable disagrees with halt"); // (R1)

  property p_run_write;
    wr_now && !hwdata[`DBC_BIT_HALT] && !read_protect && !brk_hit |=> !core_halt && core_fetch_en;
  endproperty
  a_run_write: assert property (p_run_write) else $error("run write did not release core"); // (R2)

  property p_brk_armed;
    brk_hit && st_r.arm |=> core_halt && !core_fetch_en && !brk_nop;
  endproperty
  a_brk_armed: assert property (p_brk_armed) else $error("armed breakpoint did not halt"); // (R3)

  property p_brk_nop;
    brk_hit && !st_r.arm && !core_halt && !wr_now |=> brk_nop && !core_halt;
  endproperty
  a_brk_nop: assert property (p_brk_nop) else $error("unarmed breakpoint changed halt"); // (R4)

  property p_protect_hold;
    read_protect && core_halt |=> core_halt;
  endproperty
  a_protect_hold: assert property (p_protect_hold) else $error("halt cleared under read protection"); // (R5)

  sequence s_reset_pulse;
    // A write landing right behind may raise the request again
    core_reset_req ##1 (!core_reset_req || $past(wr_now));
  endsequence
  property p_reset_stop;
    wr_now && hwdata[`DBC_BIT_RST] && hwdata[`DBC_BIT_HALT] |=> s_reset_pulse and core_halt;
  endproperty
  a_reset_stop: assert property (p_reset_stop) else $error("reset-and-stop not carried out"); // (R6)

  property p_ro_zero;
    hrdata[31:8] == 24'h000000 && hrdata[4:1] == 4'h0;
  endproperty
  a_ro_zero: assert property (p_ro_zero) else $error("read-only bits not zero"); // (R8)

  property p_read_back;
    addr_take && !hwrite && ctrl_hit(haddr) ##1 !wr_now && !brk_hit |-> hrdata[7:5] == {core_halt, st_r.arm, ack_enable};
  endproperty
  a_read_back: assert property (p_read_back) else $error("read data not register state"); // (R8)
endmodule : dbc_top

// File: sim/dbc_link_host.sv
// Purpose: Debug host model on the link byte port
// Assumes: Bytes strobed on hclk rising edges
// Notes: Port shows the inverted last byte between frames
`timescale 1ns/1ns
`include "dbc_map.svh"
module dbc_link_host (
  input wire logic hclk,
  output logic link_byte_valid,
  output logic [7:0] link_byte,
  output logic [2:0] link_op_len
);
  // ==========================================
  // Frame sender
  initial begin
    link_byte_valid = 1'b0;
    link_byte = 8'h5a;
    link_op_len = 3'h0;
  end
  // Call right after an edge; never twice in one time step
  task automatic frame(input logic [39:0] ops, input int n, input logic [2:0] len);
    logic [47:0] d;
    d = {ops, `DBC_CMD_EXEC};
    for (int i = 0; i <= n; i++) begin
      link_byte_valid <= 1'b1;
      link_byte <= d[8*i +: 8];
      link_op_len <= (i == 1) ? len : ~len;
      @(posedge hclk);
    end
    link_byte_valid <= 1'b0;
    link_byte <= ~link_byte;
  endtask : frame
endmodule : dbc_link_host

// File: sim/debugger_control_register_tb_top.sv
// Purpose: Self-checking bench of the debugger control register
// Assumes: One AHB-Lite master, hready tied to hreadyout
// Notes: Read data and link results are queued for the watcher
`timescale 1ns/1ns
`include "dbc_map.svh"
module debugger_control_register_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic read_protect = 1'b0;
  logic opcode_valid = 1'b0;
  logic [7:0] opcode = 8'h3c;
  logic hreadyout, hresp, core_halt, core_fetch_en, core_reset_req, brk_nop, ack_enable;
  logic exec_valid, exec_discard, link_byte_valid, rd_dp = 1'b0;
  logic [31:0] hrdata;
  logic [31:0] seed = 32'had66;
  logic [7:0] exec_byte, link_byte;
  logic [2:0] link_op_len;
  logic [31:0] rd_q[$];
  logic [8:0] ex_q[$];
  int n_mismatch = 0;
  int checks = 0;
  always #10 hclk = ~hclk;
  dbc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .read_protect(read_protect), .opcode_valid(opcode_valid), .opcode(opcode), .link_byte_valid(link_byte_valid),
    .link_byte(link_byte), .link_op_len(link_op_len), .core_halt(core_halt), .core_fetch_en(core_fetch_en),
    .core_reset_req(core_reset_req), .brk_nop(brk_nop), .ack_enable(ack_enable), .exec_valid(exec_valid),
    .exec_byte(exec_byte), .exec_discard(exec_discard));
  dbc_link_host host (.hclk(hclk), .link_byte_valid(link_byte_valid), .link_byte(link_byte),
    .link_op_len(link_op_len));
  // ==========================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("BAD %s exp %h got %h", what, exp, got);
      n_mismatch++;
    end
  endtask : chk
  task automatic finish_test();
    $display("Counts: %0d compares, %0d mismatches", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  // Bounded wait, a hang ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      n_mismatch++;
      finish_test();
    end
  endtask : wait_rdy
  // For reads d is the expected word
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? d : ~hwdata;
    if (!wr)
      rd_q.push_back(d);
    wait_rdy();
    #1;
  endtask : bus
  task automatic flags(input logic [7:0] d);
    chk("halt", d[7], core_halt);
    chk("fetch", !d[7], core_fetch_en);
    chk("ack", d[5], ack_enable);
    chk("rst", d[0], core_reset_req);
  endtask : flags
  task automatic breakpoint_opcode(input logic h, input logic nop);
    @(posedge hclk);
    opcode_valid <= 1'b1;
    opcode <= `DBC_BRK_OPCODE;
    @(posedge hclk);
    opcode_valid <= 1'b0;
    opcode <= 8'h3c;
    #1;
    chk("halt", h, core_halt);
    chk("nop", nop, brk_nop);
  endtask : breakpoint_opcode
  task automatic lk(input logic [39:0] ops, input int n, input logic [2:0] len);
    @(posedge hclk);
    host.frame(ops, n, len);
  endtask : lk
  // ==========================================
  // Watcher
  always @(posedge hclk) begin
    if (rd_dp)
      chk("hrdata", (rd_q.size() > 0) ? rd_q.pop_front() : 32'hdead, hrdata);
    if (exec_valid === 1'b1 || exec_discard === 1'b1)
      chk("exec", (ex_q.size() > 0) ? ex_q.pop_front() : 9'h1ff, {exec_discard, exec_valid ? exec_byte : 8'h00});
    chk("hresp", 1'b0, hresp);
    rd_dp <= hsel && hreadyout && htrans[1] && !hwrite;
  end
  // ==========================================
  // Main sequence
  initial begin
    logic [31:0] d;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, `DBC_OFF_CTRL, 32'h0);
    flags(8'h00);
    $display("test reset done");
    repeat (6) begin
      d = rnd();
      bus(1'b1, `DBC_OFF_CTRL, d);
      flags(d[7:0]);
      bus(1'b0, `DBC_OFF_CTRL, {24'h0, d[7:5], 5'h0});
    end
    bus(1'b1, 12'h004, 32'hff);
    bus(1'b0, 12'h004, 32'h0);
    bus(1'b0, `DBC_OFF_CTRL, {24'h0, d[7:5], 5'h0});
    $display("test access done");
    bus(1'b1, `DBC_OFF_CTRL, 32'h81);
    flags(8'h81);
    bus(1'b1, `DBC_OFF_CTRL, 32'h00);
    flags(8'h00);
    bus(1'b1, `DBC_OFF_CTRL, 32'h01);
    flags(8'h01);
    $display("test codes done");
    breakpoint_opcode(1'b0, 1'b1);
    bus(1'b1, `DBC_OFF_CTRL, 32'h40);
    breakpoint_opcode(1'b1, 1'b0);
    chk("fetch", 1'b0, core_fetch_en);
    $display("test breakpoint done");
    d = rnd();
    ex_q.push_back({1'b0, d[7:0]});
    ex_q.push_back({1'b0, d[15:8]});
    lk({24'h0, d[15:0]}, 2, 3'h2);
    // Appended, the last byte of the previous frame is still pending
    for (int i = 1; i <= 5; i++) begin
      ex_q.push_back({1'b0, 8'(8'h11 * i)});
    end
    lk(40'h5544332211, 5, 3'h5);
    ex_q.push_back(9'h066);
    lk(40'h66, 1, 3'h0);
    @(posedge hclk);
    read_protect <= 1'b1;
    bus(1'b1, `DBC_OFF_CTRL, 32'h00);
    chk("halt", 1'b1, core_halt);
    ex_q.push_back(9'h100);
    lk(40'h3477, 2, 3'h2);
    @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    read_protect <= 1'b0;
    #1;
    flags(8'h00);
    ex_q.push_back(9'h100);
    lk(40'h99, 1, 3'h1);
    $display("test link done");
    repeat (3) @(posedge hclk);
    chk("left", 32'h0, rd_q.size() + ex_q.size());
    finish_test();
  end
endmodule : debugger_control_register_tb_top
